// File: hw/pfs_axil.sv
// AXI4-Lite slave holding the pin control registers
`timescale 1ns/100ps
`default_nettype none
`include "pfs_map.svh"
module pfs_axil (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // Write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // Read address and data
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Control bits
    output logic [7:0] p1_dir,
    output logic [7:0] p1_sel,
    output logic [7:0] p2_dir,
    output logic [7:0] p2_sel,
    output logic [7:0] aen,
    output logic [1:0] mode,
    // Status from the pin logic
    input wire logic [7:0] pin_in_stat,
    input wire logic [7:0] pin_oe_stat
);
    logic aw_have_q, w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [7:0] p1d_q, p1s_q, p2d_q, p2s_q, aen_q;
    logic [1:0] mode_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    // Accept each channel once, hold until response drains
    assign s_awready = !aw_have_q && !bvalid_q;
    assign s_wready = !w_have_q && !bvalid_q;
    assign s_arready = !rvalid_q;
    wire do_write = aw_have_q && w_have_q && !bvalid_q;
    wire wr_hit = (awaddr_q == `PFS_OFF_P1_DIR) || (awaddr_q == `PFS_OFF_P1_SEL)
        || (awaddr_q == `PFS_OFF_P2_DIR) || (awaddr_q == `PFS_OFF_P2_SEL)
        || (awaddr_q == `PFS_OFF_AEN) || (awaddr_q == `PFS_OFF_MODE);
    wire wr_lane0 = do_write && wstrb_q[0];
    wire [31:0] rd_mux =
        (s_araddr == `PFS_OFF_P1_DIR) ? {24'h000000, p1d_q} :
        (s_araddr == `PFS_OFF_P1_SEL) ? {24'h000000, p1s_q} :
        (s_araddr == `PFS_OFF_P2_DIR) ? {24'h000000, p2d_q} :
        (s_araddr == `PFS_OFF_P2_SEL) ? {24'h000000, p2s_q} :
        (s_araddr == `PFS_OFF_AEN) ? {24'h000000, aen_q} :
        (s_araddr == `PFS_OFF_MODE) ? {30'h00000000, mode_q} :
        (s_araddr == `PFS_OFF_IN) ? {24'h000000, pin_in_stat} :
        (s_araddr == `PFS_OFF_OE) ? {24'h000000, pin_oe_stat} : 32'h00000000;
    wire rd_hit = (s_araddr[7:5] == 3'h0) && (s_araddr[1:0] == 2'h0);
    // Write channel capture and register update
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `PFS_RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
            end else if (bvalid_q && s_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    // Control registers, reset defaults all clear except P2 select bit 6 (P2.6 crystal)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1d_q <= `PFS_RST_P1;
            p1s_q <= `PFS_RST_P1;
            p2d_q <= `PFS_RST_P2_DIR;
            p2s_q <= `PFS_RST_P2_SEL;
            aen_q <= `PFS_RST_AEN;
            mode_q <= `PFS_RST_MODE;
        end else if (wr_lane0) begin
            if (awaddr_q == `PFS_OFF_P1_DIR) p1d_q <= wdata_q[7:0];
            if (awaddr_q == `PFS_OFF_P1_SEL) p1s_q <= wdata_q[7:0];
            if (awaddr_q == `PFS_OFF_P2_DIR) p2d_q <= wdata_q[7:0];
            if (awaddr_q == `PFS_OFF_P2_SEL) p2s_q <= wdata_q[7:0];
            if (awaddr_q == `PFS_OFF_AEN) aen_q <= wdata_q[7:0];
            if (awaddr_q == `PFS_OFF_MODE) mode_q <= wdata_q[1:0];
        end
    end
    // Read channel, one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `PFS_RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
        end else if (rvalid_q && s_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;
    assign p1_dir = p1d_q;
    assign p1_sel = p1s_q;
    assign p2_dir = p2d_q;
    assign p2_sel = p2s_q;
    assign aen = aen_q;
    assign mode = mode_q;
endmodule : pfs_axil
`default_nettype wire

// File: hw/pfs_sync.sv
// Three-stage synchroniser that changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pfs_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // Refuse a zero-width instance at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("pfs_sync width must be positive");
    end
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
    // Stage one feeds only stage two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (agree & s3_q) | (~agree & out_q);
        end
    end
    assign sync_out = out_q;
endmodule : pfs_sync
`default_nettype wire

// File: hw/pfs_top.sv
// Pin function multiplexer for port 1 bit 7 and port 2 bits 0 to 6
// Summary of operation
// - P1.7: select clear is GPIO by direction; direction and select drive timer output 2.
// - Test-port active hands P1.7 to test data out/in, ignoring direction and select.
// - After reset all covered pins but P2.6 are GPIO with direction, select, analog cleared; P2.6 select is set.
// - P2.0: direction and select output auxiliary clock; analog enable gives channel 0.
// - P2.2: capture input 0 alt, timer output 0, or analog channel 2.
// - P2.1: timer inverted clock in, sub-main clock out, or analog channel 1.
// - P2.3: capture input 1 alt, timer output 1, or channel 3/negative reference.
// - P2.4: timer output 2 when selected output; analog gives channel 4/positive reference.
// - Analog enable kills that pin's output driver and input Schmitt buffer.
// - P2.5: selected output ties to ground; resistor-oscillator mode overrides all.
// - P2.6: select clear is GPIO, select set is crystal input; crystal is default.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pfs_map.svh"
module pfs_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Pins: index 0 is P1.7, indices 1..7 are P2.0..P2.6
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    // General purpose output data and synchronised input data
    input wire logic [7:0] gpio_out,
    output logic [7:0] gpio_in,
    // Test port
    input wire logic test_port_active,
    input wire logic test_data_out,
    input wire logic test_data_oe,
    output logic test_data_in,
    // Timer unit
    input wire logic [2:0] first_timer_unit_out,
    output logic capture_input0_alt,
    output logic capture_input1_alt,
    output logic timer_inverted_clock_in,
    // Clocks
    input wire logic aux_clock,
    input wire logic sub_main_clock,
    output logic crystal_input,
    output logic crystal_input_en,
    output logic osc_resistor_en,
    // Analog switches per pin
    output logic [7:0] analog_switch_en,
    output logic [7:0] schmitt_en,
    // Function status per pin
    output pfs_pkg::pfs_fn_t [7:0] pin_function
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register slave
    logic [7:0] p1_dir, p1_sel, p2_dir, p2_sel, aen;
    logic [1:0] mode;
    logic [7:0] sync_in;
    logic [7:0] stat_oe;
    pfs_axil u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .p1_dir(p1_dir),
        .p1_sel(p1_sel),
        .p2_dir(p2_dir),
        .p2_sel(p2_sel),
        .aen(aen),
        .mode(mode),
        .pin_in_stat(sync_in),
        .pin_oe_stat(stat_oe)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin control vectors gathered into pin order
    wire [7:0] dir_v = {p2_dir[6:0], p1_dir[`PFS_P1_PIN]};
    wire [7:0] sel_v = {p2_sel[6:0], p1_sel[`PFS_P1_PIN]};
    // Analog only exists on P2.0..P2.4; others never switch to the converter
    wire [7:0] ana_v = {2'h0, aen[4:0], 1'b0};
    wire test_mode = mode[`PFS_MODE_TEST] | test_port_active;
    wire rosc_mode = mode[`PFS_MODE_ROSC];
    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral output per pin when selected as output
    wire [7:0] periph_val = {
        1'b0,                    // P2.6 crystal, no digital output
        1'b0,                    // P2.5 ties to digital ground
        first_timer_unit_out[2], // P2.4
        first_timer_unit_out[1], // P2.3
        first_timer_unit_out[0], // P2.2
        sub_main_clock,          // P2.1
        aux_clock,               // P2.0
        first_timer_unit_out[2]  // P1.7
    };
    // Pins whose selected function may drive with direction 1
    // P2.5 drives its ground level, P2.6 crystal never drives
    wire [7:0] periph_can_drive = 8'h7F;
    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin override flags
    wire [7:0] ovr_v = {sel_v[7], rosc_mode, 5'h00, test_mode};
    ////////////////////////////////////////////////////////////////////////////////
    // Output enable and value per pin, analog first, then overrides
    logic [7:0] oe_v;
    logic [7:0] val_v;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            wire sel_out = sel_v[gi] & dir_v[gi] & periph_can_drive[gi];
            wire gp_oe = ~sel_v[gi] & dir_v[gi];
            // Analog kills the driver whatever else is set
            assign oe_v[gi] = ana_v[gi] ? 1'b0 :
                ovr_v[gi] ? ((gi == 0) ? test_data_oe : 1'b0) :
                (sel_out | gp_oe);
            assign val_v[gi] = (ovr_v[gi] && gi == 0) ? test_data_out :
                sel_v[gi] ? periph_val[gi] : gpio_out[gi];
            assign schmitt_en[gi] = ~ana_v[gi];
            assign analog_switch_en[gi] = ana_v[gi];
            assign pin_function[gi] = ana_v[gi] ? pfs_pkg::PFS_FN_ANALOG :
                ovr_v[gi] ? pfs_pkg::PFS_FN_OVERRIDE :
                sel_v[gi] ? pfs_pkg::PFS_FN_PERIPH : pfs_pkg::PFS_FN_GPIO;
        end
    endgenerate
    // Test port takes P1.7 regardless of direction and select
    assign pin_oe = oe_v;
    assign stat_oe = oe_v;
    ////////////////////////////////////////////////////////////////////////////////
    // Output value registered so data outputs come from flip-flops
    logic [7:0] pin_o_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o_q <= 8'h00;
        end else begin
            pin_o_q <= val_v;
        end
    end
    assign pin_o = pin_o_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Input path: pins are asynchronous, gated by the Schmitt enable
    pfs_sync #(.WIDTH(8)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_i & schmitt_en),
        .sync_out(sync_in)
    );
    assign gpio_in = sync_in;
    ////////////////////////////////////////////////////////////////////////////////
    // Inputs routed to peripherals; zero when not selected as input
    wire in_sel_1 = sel_v[2] & ~dir_v[2] & ~ana_v[2];
    wire in_sel_2 = sel_v[3] & ~dir_v[3] & ~ana_v[3];
    wire in_sel_3 = sel_v[4] & ~dir_v[4] & ~ana_v[4];
    logic cap0_q, cap1_q, tclk_q, tdi_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap0_q <= 1'b0;
            cap1_q <= 1'b0;
            tclk_q <= 1'b0;
            tdi_q <= 1'b0;
        end else begin
            tclk_q <= in_sel_1 & sync_in[2];
            cap0_q <= in_sel_2 & sync_in[3];
            cap1_q <= in_sel_3 & sync_in[4];
            tdi_q <= test_mode & sync_in[0];
        end
    end
    assign timer_inverted_clock_in = tclk_q;
    assign capture_input0_alt = cap0_q;
    assign capture_input1_alt = cap1_q;
    assign test_data_in = tdi_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator connections
    assign osc_resistor_en = rosc_mode;
    assign crystal_input_en = sel_v[7];
    assign crystal_input = pin_i[7] & sel_v[7];
endmodule : pfs_top
`default_nettype wire

// File: shared/pfs_map.svh
// Register offsets, field positions and reset values for the pin function select block
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
`define PFS_OFF_P1_DIR 8'h00
`define PFS_OFF_P1_SEL 8'h04
`define PFS_OFF_P2_DIR 8'h08
`define PFS_OFF_P2_SEL 8'h0C
`define PFS_OFF_AEN 8'h10
`define PFS_OFF_MODE 8'h14
`define PFS_OFF_IN 8'h18
`define PFS_OFF_OE 8'h1C
`define PFS_RST_P1 8'h00
`define PFS_RST_P2_DIR 8'h00
`define PFS_RST_P2_SEL 8'h40
`define PFS_RST_AEN 8'h00
`define PFS_RST_MODE 2'h0
`define PFS_MODE_TEST 0
`define PFS_MODE_ROSC 1
`define PFS_P1_PIN 7
`define PFS_RESP_OKAY 2'h0
`define PFS_RESP_SLVERR 2'h2
`endif

// File: shared/pfs_pkg.sv
// Types shared by the pin function select block
`default_nettype none
package pfs_pkg;
    // Function chosen per pin, for visibility only
    typedef enum logic [2:0] {
        PFS_FN_GPIO = 3'h0,
        PFS_FN_PERIPH = 3'h1,
        PFS_FN_ANALOG = 3'h3,
        PFS_FN_OVERRIDE = 3'h2
    } pfs_fn_t;
endpackage : pfs_pkg
`default_nettype wire

// File: verif/pfs_far_side.sv
// Board and peripheral model facing the pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module pfs_far_side (
    // Pin side
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] board_lvl,
    output logic [7:0] pin_i,
    // Sources: timer 0..2, aux, sub-main
    input wire logic [4:0] src,
    output logic [2:0] first_timer_unit_out,
    output logic aux_clock,
    output logic sub_main_clock
);
    // Wire level: our drive where enabled, board level where released
    assign pin_i = (pin_o & pin_oe) | (board_lvl & ~pin_oe);
    // Clocks held still so that routed levels can be compared
    assign first_timer_unit_out = src[2:0];
    assign aux_clock = src[3];
    assign sub_main_clock = src[4];
endmodule : pfs_far_side
`default_nettype wire

// File: verif/pfs_top_sva.sv
// Port-level assertions for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module pfs_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    // Pins and overrides
    input wire logic [7:0] pin_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic test_port_active,
    input wire logic test_data_out,
    input wire logic test_data_oe,
    input wire logic crystal_input,
    input wire logic crystal_input_en,
    input wire logic osc_resistor_en,
    input wire logic [7:0] analog_switch_en,
    input wire logic [7:0] schmitt_en
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // Handshake steps of one write and one read
    sequence wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence rd_taken;
        s_arvalid && s_arready;
    endsequence
    wr_resp_a: assert property (wr_taken |-> ##[1:2] s_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (rd_taken |=> s_rvalid)
        else $error("read response late");
    ////////////////////////////////////////////////////////////////
    // Overrides and analog isolation
    test_oe_a: assert property (test_port_active |-> pin_oe[0] == test_data_oe)
        else $error("test port enable not on pin");
    test_out_a: assert property (test_port_active && $past(test_port_active)
        |-> pin_o[0] == $past(test_data_out)) else $error("test port data not on pin");
    analog_drv_a: assert property ((analog_switch_en & pin_oe) == 8'h00)
        else $error("driver on while analog");
    analog_sch_a: assert property ((analog_switch_en & schmitt_en) == 8'h00)
        else $error("input buffer on while analog");
    analog_pins_a: assert property ((analog_switch_en & 8'hC1) == 8'h00)
        else $error("analog switch on a digital-only pin");
    rosc_drv_a: assert property (osc_resistor_en |-> !pin_oe[6])
        else $error("resistor pin driven");
    xtal_drv_a: assert property (crystal_input_en |-> !pin_oe[7] && crystal_input == pin_i[7])
        else $error("crystal pin wrong");
    // Checked during reset too, so the disable is turned off here
    reset_idle_a: assert property (disable iff (1'b0) !aresetn
        |=> pin_oe == 8'h00 && !s_bvalid && !s_rvalid) else $error("not idle after reset");
endmodule : pfs_top_sva
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "pfs_map.svh"
module tb;
    logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, aux_clock, sub_main_clock;
    logic [7:0] s_awaddr, s_araddr, pin_i, pin_o, pin_oe, gpio_out, gpio_in, board_lvl, b;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic [7:0] analog_switch_en, schmitt_en;
    logic [4:0] src, p, e;
    logic [2:0] first_timer_unit_out, cap;
    logic test_port_active, test_data_out, test_data_oe, test_data_in;
    logic capture_input0_alt, capture_input1_alt, timer_inverted_clock_in;
    logic crystal_input, crystal_input_en, osc_resistor_en;
    pfs_pkg::pfs_fn_t [7:0] pin_function;
    int err_count, n_compared;
    assign cap = {capture_input1_alt, capture_input0_alt, timer_inverted_clock_in};
    pfs_top uut (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_i, .pin_o, .pin_oe, .gpio_out,
        .gpio_in, .test_port_active, .test_data_out, .test_data_oe, .test_data_in,
        .first_timer_unit_out, .capture_input0_alt, .capture_input1_alt,
        .timer_inverted_clock_in, .aux_clock, .sub_main_clock, .crystal_input,
        .crystal_input_en, .osc_resistor_en, .analog_switch_en, .schmitt_en, .pin_function
    );
    pfs_far_side far (
        .pin_o, .pin_oe, .board_lvl, .pin_i, .src, .first_timer_unit_out, .aux_clock,
        .sub_main_clock
    );
    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    // Sample past the edge so the design's updates have landed
    task automatic step(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask : step
    task automatic drv(input logic [7:0] g, input logic [4:0] s, input logic [7:0] bl);
        @(posedge aclk);
        gpio_out <= g;
        src <= s;
        board_lvl <= bl;
    endtask : drv
    // Each channel is released at its own accept edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `PFS_RESP_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        @(posedge aclk);
        while (s_bvalid !== 1'b1 && n < 50) begin
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
            n++;
            @(posedge aclk);
        end
        s_awvalid <= 1'b0;
        s_wvalid <= 1'b0;
        s_bready <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("ERROR %0t: no write response", $time);
        end
        chk(s_bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] er = `PFS_RESP_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        @(posedge aclk);
        while (s_rvalid !== 1'b1 && n < 50) begin
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
            n++;
            @(posedge aclk);
        end
        s_arvalid <= 1'b0;
        s_rready <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("ERROR %0t: no read response", $time);
        end
        chk(s_rdata, x);
        chk(s_rresp, er);
    endtask : rd
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Whole run is a few hundred cycles; this is far past it
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = {16'h0000, 32'h0, 4'hF};
        {test_port_active, test_data_out, test_data_oe} = 3'h0;
        {gpio_out, src, board_lvl} = {8'h00, 5'h00, 8'h00};
        err_count = 0;
        n_compared = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        step(1);
        chk({pin_oe, crystal_input_en}, 9'h001);
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), (i == 3) ? 32'h40 : 32'h0);
        end
        rd(8'h20, 32'h0, `PFS_RESP_SLVERR);
        wr(8'h24, 32'hFF, `PFS_RESP_SLVERR);
        // Write with lane 0 off is answered but changes nothing
        @(posedge aclk);
        s_wstrb <= 4'h0;
        wr(`PFS_OFF_P1_DIR, 32'h80);
        s_wstrb <= 4'hF;
        rd(`PFS_OFF_P1_DIR, 32'h0);
        // P1.7 as output, then as timer output 2
        drv(8'h01, 5'h00, 8'h01);
        wr(`PFS_OFF_P1_DIR, 32'h80);
        step(2);
        chk({pin_oe[0], pin_o[0]}, 2'b11);
        wr(`PFS_OFF_P1_SEL, 32'h80);
        step(2);
        chk({pin_oe[0], pin_o[0]}, 2'b10);
        // Test port wins over direction and select
        wr(`PFS_OFF_MODE, 32'h1);
        @(posedge aclk);
        test_data_oe <= 1'b1;
        test_data_out <= 1'b1;
        step(2);
        chk({pin_oe[0], pin_o[0]}, 2'b11);
        @(posedge aclk);
        test_data_oe <= 1'b0;
        step(4);
        chk({pin_oe[0], test_data_in}, 2'b01);
        wr(`PFS_OFF_MODE, 32'h0);
        @(posedge aclk);
        test_port_active <= 1'b1;
        step(2);
        chk(pin_oe[0], 1'b0);
        @(posedge aclk);
        test_port_active <= 1'b0;
        wr(`PFS_OFF_P1_SEL, 32'h0);
        wr(`PFS_OFF_P1_DIR, 32'h0);
        step(6);
        chk({pin_oe[0], gpio_in[0]}, 2'b01);
        // Peripheral outputs, GPIO data set opposite so a wrong route shows
        wr(`PFS_OFF_P2_DIR, 32'h1F);
        wr(`PFS_OFF_P2_SEL, 32'h5F);
        for (int k = 0; k < 2; k++) begin
            p = k ? 5'h0A : 5'h15;
            e = {p[2], p[1], p[0], p[4], p[3]};
            drv({2'b00, ~e, 1'b0}, p, 8'h00);
            step(2);
            chk({pin_oe[5:1], pin_o[5:1]}, {5'h1F, e});
        end
        rd(`PFS_OFF_OE, 32'h3E);
        // Peripheral inputs
        wr(`PFS_OFF_P2_DIR, 32'h0);
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h08 : 8'h14;
            drv(8'h00, 5'h00, b);
            step(6);
            chk(cap, b[4:2]);
        end
        rd(`PFS_OFF_IN, 32'h08);
        // Analog enable beats direction and select
        wr(`PFS_OFF_P2_DIR, 32'h1F);
        wr(`PFS_OFF_AEN, 32'h1F);
        step(1);
        chk({pin_oe[5:1], schmitt_en[5:1]}, 10'h000);
        chk(analog_switch_en, 8'h3E);
        chk(pin_function, 24'h41B6D8);
        wr(`PFS_OFF_AEN, 32'h0);
        // P2.5 ground, no function, resistor; P2.6 crystal then GPIO
        drv(8'hFF, 5'h00, 8'h00);
        wr(`PFS_OFF_P2_DIR, 32'h60);
        wr(`PFS_OFF_P2_SEL, 32'h60);
        step(2);
        chk({pin_oe[7:6], pin_o[6]}, 3'b010);
        wr(`PFS_OFF_MODE, 32'h2);
        step(1);
        chk({osc_resistor_en, pin_oe[6]}, 2'b10);
        wr(`PFS_OFF_MODE, 32'h0);
        wr(`PFS_OFF_P2_DIR, 32'h40);
        step(1);
        chk(pin_oe[6], 1'b0);
        wr(`PFS_OFF_P2_SEL, 32'h0);
        step(2);
        chk({crystal_input_en, pin_oe[7], pin_o[7]}, 3'b011);
        close_out();
    end
endmodule : tb
bind pfs_top pfs_top_sva u_sva (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid,
    .s_arvalid, .s_arready, .s_rvalid, .pin_i, .pin_o, .pin_oe, .test_port_active,
    .test_data_out, .test_data_oe, .crystal_input, .crystal_input_en, .osc_resistor_en,
    .analog_switch_en, .schmitt_en
);
`default_nettype wire
